//--- hesmw_top.sv
// Host to controller mailbox and shared memory window
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "hesmw_map.svh"
module hesmw_top (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic HOST_CS,
  input wire logic HOST_WE,
  input wire logic [3:0] HOST_ADDR,
  input wire logic [7:0] HOST_WDATA,
  output logic HOST_READY,
  output logic [7:0] HOST_RDATA,
  output logic HOST_DONE,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [31:0] MEM_ADDR,
  output logic [3:0] MEM_BE,
  output logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic H2C_IRQ,
  output logic HOST_EVENT_OUT_N,
  output logic LOW_POWER
);

  hesmw_pkg::hesmw_state_t state_q;
  hesmw_pkg::hesmw_width_t acc_t;
  logic [7:0] h2c_q, c2h_q, addr_lo_q, addr_hi_q;
  logic [3:0][7:0] data_q;
  logic [15:0] src_q, mask_q, src_set, src_clr;
  logic [31:0] base_q [2];
  logic [31:0] lim_q [2];
  logic [12:0] window_word_address;
  logic [14:0] offset;
  logic region;
  logic [15:0] rlim, wlim;
  logic rd_ok, wr_ok, perm, host_take, data_sel, need_mem;
  logic inc_cond, inc_now, ec_wr, ec_rd, unmapped;
  logic [1:0] hb;
  logic [3:0] lanes;
  logic [3:0][7:0] data_new;
  logic [1:0] pend_byte_q;
  logic pend_inc_q, mem_req_q, mem_we_q, done_q, irq_q, evt_n_q, lp_q;
  logic [3:0] mem_be_q;
  logic [31:0] mem_addr_q, mem_wdata_q, prdata_q;
  logic [7:0] rdata_q, host_val;
  logic host_software_event, c2h_event;

  // Limits wider than a window are cut to one window
  function automatic logic [15:0] win_clamp(input logic [15:0] lim);
    win_clamp = (lim > `HESMW_WIN_MAX) ? `HESMW_WIN_MAX : lim;
  endfunction

  function automatic logic [3:0] lane_decode(
    input logic we,
    input logic [1:0] b,
    input hesmw_pkg::hesmw_width_t t
  );
    lane_decode = 4'h0;
    case (t)
      hesmw_pkg::HESMW_W8: lane_decode = 4'h1 << b;
      hesmw_pkg::HESMW_W16: begin
        if (b == (we ? 2'h1 : 2'h0)) lane_decode = 4'h3;
        if (b == (we ? 2'h3 : 2'h2)) lane_decode = 4'hc;
      end
      default: begin
        if (b == (we ? 2'h3 : 2'h0)) lane_decode = 4'hf;
      end
    endcase
  endfunction

  // Window address and permission
  assign acc_t = hesmw_pkg::hesmw_width_t'(addr_lo_q[1:0]);
  assign window_word_address = {addr_hi_q[6:0], addr_lo_q[7:2]};
  assign offset = {window_word_address, 2'b00};
  assign region = addr_hi_q[`HESMW_REGION_BIT];
  assign rlim = win_clamp(lim_q[region][15:0]);
  assign wlim = win_clamp(lim_q[region][31:`HESMW_WLIM_LSB]);
  assign rd_ok = {1'b0, offset} < rlim;
  assign wr_ok = {1'b0, offset} < wlim;

  // Host byte port; one byte per access, wider moves are internal
  assign HOST_READY = (state_q == hesmw_pkg::HESMW_IDLE);
  assign host_take = HOST_CS && HOST_READY;
  assign hb = HOST_ADDR[1:0];
  assign data_sel = (HOST_ADDR[3:2] == `HESMW_H_DATA_GRP);
  assign lanes = lane_decode(HOST_WE, hb, acc_t);
  assign perm = HOST_WE ? wr_ok : rd_ok;
  assign need_mem = host_take && data_sel && (lanes != 4'h0) && perm;
  assign inc_cond = (acc_t == hesmw_pkg::HESMW_W32I) && (hb == 2'h3) &&
                    (!HOST_WE || wr_ok);
  assign inc_now = host_take && data_sel && inc_cond && !need_mem;

  always_comb begin
    data_new = data_q;
    data_new[hb] = HOST_WDATA;
  end

  always_comb begin
    case (HOST_ADDR)
      `HESMW_H_H2C: host_val = h2c_q;
      `HESMW_H_C2H: host_val = c2h_q;
      `HESMW_H_ADDR_LO: host_val = addr_lo_q;
      `HESMW_H_ADDR_HI: host_val = addr_hi_q;
      `HESMW_H_SRC_LO: host_val = src_q[7:0];
      `HESMW_H_SRC_HI: host_val = src_q[15:8];
      `HESMW_H_MASK_LO: host_val = mask_q[7:0];
      `HESMW_H_MASK_HI: host_val = mask_q[15:8];
      default: host_val = data_sel ? data_q[hb] : 8'h00;
    endcase
  end

  // Access sequencer; memory may stall, so the host port waits
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= hesmw_pkg::HESMW_IDLE;
    end else begin
      case (state_q)
        hesmw_pkg::HESMW_IDLE: begin
          if (need_mem) state_q <= hesmw_pkg::HESMW_MEM;
        end
        hesmw_pkg::HESMW_MEM: begin
          if (MEM_ACK) state_q <= hesmw_pkg::HESMW_IDLE;
        end
        default: state_q <= hesmw_pkg::HESMW_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_be_q <= 4'h0;
      mem_addr_q <= 32'h0000_0000;
      mem_wdata_q <= 32'h0000_0000;
      pend_byte_q <= 2'h0;
      pend_inc_q <= 1'b0;
    end else if (need_mem) begin
      mem_req_q <= 1'b1;
      mem_we_q <= HOST_WE;
      mem_be_q <= lanes;
      mem_addr_q <= {base_q[region][31:2], 2'b00} + {17'h0_0000, offset};
      mem_wdata_q <= data_new;
      pend_byte_q <= hb;
      pend_inc_q <= inc_cond;
    end else if (MEM_ACK) begin
      mem_req_q <= 1'b0;
    end
  end

  assign MEM_REQ = mem_req_q;
  assign MEM_WE = mem_we_q;
  assign MEM_BE = mem_be_q;
  assign MEM_ADDR = mem_addr_q;
  assign MEM_WDATA = mem_wdata_q;

  // Data register lanes: host byte writes, memory read fills
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          data_q[g] <= `HESMW_BYTE_RST;
        end else if (host_take && data_sel && HOST_WE && hb == g) begin
          data_q[g] <= HOST_WDATA;
        end else if (mem_req_q && MEM_ACK && !mem_we_q && mem_be_q[g]) begin
          data_q[g] <= MEM_RDATA[8*g +: 8];
        end
      end
    end
  endgenerate

  // Address register and auto-increment
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      addr_lo_q <= `HESMW_BYTE_RST;
      addr_hi_q <= `HESMW_BYTE_RST;
    end else if (host_take && HOST_WE && HOST_ADDR == `HESMW_H_ADDR_LO) begin
      addr_lo_q <= HOST_WDATA;
    end else if (host_take && HOST_WE && HOST_ADDR == `HESMW_H_ADDR_HI) begin
      addr_hi_q <= HOST_WDATA;
    end else if (inc_now || (mem_req_q && MEM_ACK && pend_inc_q)) begin
      {addr_hi_q[6:0], addr_lo_q[7:2]} <= window_word_address + 13'h0001;
    end
  end

  // Host read data and completion pulse
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= `HESMW_BYTE_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= (host_take && !need_mem) || (mem_req_q && MEM_ACK);
      if (host_take && !need_mem && !HOST_WE) begin
        rdata_q <= host_val;
      end else if (mem_req_q && MEM_ACK && !mem_we_q) begin
        rdata_q <= MEM_RDATA[8*pend_byte_q +: 8];
      end
    end
  end

  assign HOST_RDATA = rdata_q;
  assign HOST_DONE = done_q;

  // Mailboxes
  assign ec_wr = PSEL && PENABLE && PWRITE;
  assign ec_rd = PSEL && !PENABLE && !PWRITE;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      h2c_q <= `HESMW_BYTE_RST;
      c2h_q <= `HESMW_BYTE_RST;
      irq_q <= 1'b0;
    end else begin
      irq_q <= host_take && HOST_WE && HOST_ADDR == `HESMW_H_H2C;
      if (host_take && HOST_WE && HOST_ADDR == `HESMW_H_H2C) begin
        h2c_q <= HOST_WDATA;
      end
      if (ec_wr && PADDR == `HESMW_A_C2H) begin
        c2h_q <= PWDATA[7:0];
      end
    end
  end

  assign H2C_IRQ = irq_q;

  // Event sources: set wins over a host clear in the same cycle
  assign src_set = ((ec_wr && PADDR == `HESMW_A_C2H) ? 16'h0001 : 16'h0000) |
                   ((ec_wr && PADDR == `HESMW_A_SWSET) ?
                    {PWDATA[15:1], 1'b0} : 16'h0000);
  assign src_clr = (host_take && HOST_WE && HOST_ADDR == `HESMW_H_SRC_LO) ?
                   {8'h00, HOST_WDATA} :
                   (host_take && HOST_WE && HOST_ADDR == `HESMW_H_SRC_HI) ?
                   {HOST_WDATA, 8'h00} : 16'h0000;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      src_q <= `HESMW_SRC_RST;
    end else begin
      src_q <= (src_q & ~src_clr) | src_set;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask_q <= `HESMW_MASK_RST;
    end else if (host_take && HOST_WE && HOST_ADDR == `HESMW_H_MASK_LO) begin
      mask_q[7:0] <= HOST_WDATA;
    end else if (host_take && HOST_WE && HOST_ADDR == `HESMW_H_MASK_HI) begin
      mask_q[15:8] <= HOST_WDATA;
    end
  end

  assign c2h_event = src_q[`HESMW_SRC_C2H] && !mask_q[`HESMW_SRC_C2H];
  assign host_software_event = |(src_q[15:1] & ~mask_q[15:1]);

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      evt_n_q <= 1'b1;
    end else begin
      evt_n_q <= !(c2h_event || host_software_event);
    end
  end

  assign HOST_EVENT_OUT_N = evt_n_q;

  // Region registers, only the controller bus reaches them
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      base_q[0] <= `HESMW_BASE_RST;
      base_q[1] <= `HESMW_BASE_RST;
      lim_q[0] <= `HESMW_LIM_RST;
      lim_q[1] <= `HESMW_LIM_RST;
    end else if (ec_wr) begin
      case (PADDR)
        `HESMW_A_BASE0: base_q[0] <= PWDATA;
        `HESMW_A_LIM0: lim_q[0] <= PWDATA;
        `HESMW_A_BASE1: base_q[1] <= PWDATA;
        `HESMW_A_LIM1: lim_q[1] <= PWDATA;
        default: ;
      endcase
    end
  end

  // APB slave: zero wait states, read data latched in setup
  assign unmapped = !(PADDR inside {`HESMW_A_H2C, `HESMW_A_C2H,
    `HESMW_A_BASE0, `HESMW_A_LIM0, `HESMW_A_BASE1, `HESMW_A_LIM1,
    `HESMW_A_SWSET, `HESMW_A_STAT});
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && unmapped;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_q <= 32'h0000_0000;
    end else if (ec_rd) begin
      case (PADDR)
        `HESMW_A_H2C: prdata_q <= {24'h00_0000, h2c_q};
        `HESMW_A_C2H: prdata_q <= {24'h00_0000, c2h_q};
        `HESMW_A_BASE0: prdata_q <= base_q[0];
        `HESMW_A_LIM0: prdata_q <= lim_q[0];
        `HESMW_A_BASE1: prdata_q <= base_q[1];
        `HESMW_A_LIM1: prdata_q <= lim_q[1];
        `HESMW_A_STAT: prdata_q <= {mask_q, src_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign PRDATA = prdata_q;

  // Low power from the cycle after neither port selects the block and no memory request is pending
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lp_q <= 1'b1;
    end else begin
      lp_q <= !(HOST_CS || PSEL || mem_req_q);
    end
  end

  assign LOW_POWER = lp_q;

  default clocking a_clk @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);
  a_h2c_irq_pulse: assert property (
    host_take && HOST_WE && HOST_ADDR == `HESMW_H_H2C |=> H2C_IRQ)
    else $error("mailbox write gave no irq");
  a_h2c_irq_cause: assert property (
    H2C_IRQ |-> $past(host_take && HOST_WE && HOST_ADDR == `HESMW_H_H2C))
    else $error("controller irq without mailbox write");
  a_c2h_sets_src: assert property (
    ec_wr && PADDR == `HESMW_A_C2H |=> src_q[`HESMW_SRC_C2H])
    else $error("controller mailbox write lost");
  a_event_out_mask: assert property (
    1'b1 |=> HOST_EVENT_OUT_N == !$past(|(src_q & ~mask_q)))
    else $error("host event disagrees with mask");
  a_idle_low_power: assert property (
    !HOST_CS && !PSEL && !mem_req_q |=> LOW_POWER)
    else $error("idle block not in low power");
  a_ro_write_blocked: assert property (
    host_take && HOST_WE && data_sel && !wr_ok |=> !MEM_REQ &&
    data_q[$past(hb)] == $past(HOST_WDATA))
    else $error("write outside write area");
  a_noacc_read_keep: assert property (
    host_take && !HOST_WE && data_sel && !rd_ok |=> !MEM_REQ &&
    data_q == $past(data_q)) else $error("no-access read changed data");
  a_oob_read_inc: assert property (
    host_take && !HOST_WE && data_sel && hb == 2'h3 && !rd_ok &&
    acc_t == hesmw_pkg::HESMW_W32I |=>
    window_word_address == $past(window_word_address) + 13'h0001)
    else $error("byte 3 read did not advance");
  a_w32_store_all: assert property (
    host_take && HOST_WE && data_sel && hb == 2'h3 && wr_ok &&
    acc_t == hesmw_pkg::HESMW_W32 |=> MEM_REQ && MEM_WE && MEM_BE == 4'hf)
    else $error("32-bit store missing");
  a_w8_lane_match: assert property (
    need_mem && acc_t == hesmw_pkg::HESMW_W8 |=>
    MEM_BE == (4'h1 << $past(hb))) else $error("8-bit lane wrong");

endmodule
`default_nettype wire

//--- hesmw_map.svh
// Offsets, field positions and reset values of the shared memory window
`ifndef HESMW_MAP_SVH
`define HESMW_MAP_SVH
`define HESMW_H_H2C 4'h0
`define HESMW_H_C2H 4'h1
`define HESMW_H_ADDR_LO 4'h2
`define HESMW_H_ADDR_HI 4'h3
`define HESMW_H_SRC_LO 4'h8
`define HESMW_H_SRC_HI 4'h9
`define HESMW_H_MASK_LO 4'ha
`define HESMW_H_MASK_HI 4'hb
`define HESMW_H_DATA_GRP 2'b01
`define HESMW_A_H2C 12'h000
`define HESMW_A_C2H 12'h004
`define HESMW_A_BASE0 12'h008
`define HESMW_A_LIM0 12'h00c
`define HESMW_A_BASE1 12'h010
`define HESMW_A_LIM1 12'h014
`define HESMW_A_SWSET 12'h018
`define HESMW_A_STAT 12'h01c
`define HESMW_SRC_C2H 0
`define HESMW_REGION_BIT 7
`define HESMW_WLIM_LSB 16
`define HESMW_WIN_MAX 16'h8000
`define HESMW_BYTE_RST 8'h00
`define HESMW_SRC_RST 16'h0000
`define HESMW_MASK_RST 16'h0000
`define HESMW_BASE_RST 32'h0000_0000
`define HESMW_LIM_RST 32'h0000_0000
`endif

//--- hesmw_pkg.sv
// Types of the shared memory window
`default_nettype none
package hesmw_pkg;
  typedef enum logic [1:0] {
    HESMW_W8 = 2'b00,
    HESMW_W16 = 2'b01,
    HESMW_W32 = 2'b10,
    HESMW_W32I = 2'b11
  } hesmw_width_t;
  typedef enum logic {
    HESMW_IDLE = 1'b0,
    HESMW_MEM = 1'b1
  } hesmw_state_t;
endpackage
`default_nettype wire

//--- hesmw_mem_model.sv
// Controller memory model answering the window's requests
`timescale 1ns/1ps
`default_nettype none
module hesmw_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic [3:0] dly,
  output logic [31:0] rdata,
  output logic ack
);
  logic [31:0] mem [0:63];
  logic [31:0] junk_q;
  logic [3:0] cnt_q;
  int wr_count = 0;
  int rd_count = 0;
  // Slow answers: ack only once dly cycles of request have passed
  assign ack = req && (cnt_q == dly);
  // Data toggles outside an answer so a stale capture shows up
  assign rdata = ack ? mem[addr[7:2]] : junk_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      junk_q <= 32'h0f0f_3c3c;
    end else begin
      cnt_q <= (req && !ack) ? cnt_q + 4'h1 : 4'h0;
      junk_q <= ~junk_q;
    end
  end
  always @(posedge clk) begin
    if (req && ack && we) begin
      wr_count <= wr_count + 1;
      for (int i = 0; i < 4; i++) begin
        if (be[i]) mem[addr[7:2]][8*i +: 8] <= wdata[8*i +: 8];
      end
    end
    if (req && ack && !we) rd_count <= rd_count + 1;
  end
endmodule
`default_nettype wire

//--- hesmw_top_test.sv
// Self-checking bench of the shared memory window
`timescale 1ns/1ps
`default_nettype none
`include "hesmw_map.svh"
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module hesmw_top_test;
  logic SYS_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] PRDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, aq, e;
  logic PREADY, PSLVERR, HOST_READY, HOST_DONE, MEM_REQ, MEM_WE, MEM_ACK;
  logic H2C_IRQ, HOST_EVENT_OUT_N, LOW_POWER, aerr;
  logic HOST_CS = 1'b0, HOST_WE = 1'b0;
  logic [3:0] HOST_ADDR = 4'h0, MEM_BE, dly = 4'h0;
  logic [7:0] HOST_WDATA = 8'h00, HOST_RDATA, hq;
  int err_count = 0, check_count = 0, irq_count = 0, lp_low = 0, rc;
  always #5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    if (H2C_IRQ === 1'b1) irq_count++;
    if (LOW_POWER === 1'b0) lp_low++;
  end
  hesmw_top u_hesmw_top (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .HOST_CS(HOST_CS),
    .HOST_WE(HOST_WE), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
    .HOST_READY(HOST_READY), .HOST_RDATA(HOST_RDATA),
    .HOST_DONE(HOST_DONE), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR), .MEM_BE(MEM_BE), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK), .H2C_IRQ(H2C_IRQ),
    .HOST_EVENT_OUT_N(HOST_EVENT_OUT_N), .LOW_POWER(LOW_POWER));
  hesmw_mem_model u_mem (.clk(SYS_CLK), .rst_n(ARST_N), .req(MEM_REQ),
    .we(MEM_WE), .addr(MEM_ADDR), .be(MEM_BE), .wdata(MEM_WDATA),
    .dly(dly), .rdata(MEM_RDATA), .ack(MEM_ACK));
  function automatic logic [31:0] pat(input int i);
    return {8'(i + 64), 8'(i + 48), 8'(i + 32), 8'(i + 16)};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic ap(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    aq = PRDATA;
    aerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic ac(input logic [11:0] a, input logic [31:0] x);
    ap(1'b0, a, 32'h0000_0000);
    `CHK("prdata", x, aq)
  endtask
  // Host side always moves a single byte, whatever the memory width
  task automatic hop(input logic w, input logic [3:0] a,
      input logic [7:0] d);
    HOST_CS <= 1'b1;
    HOST_WE <= w;
    HOST_ADDR <= a;
    HOST_WDATA <= d;
    // No local limit: only the watchdog may end a stuck wait
    do begin
      @(posedge SYS_CLK);
    end while (HOST_READY !== 1'b1);
    HOST_CS <= 1'b0;
    do begin
      @(posedge SYS_CLK);
    end while (HOST_DONE !== 1'b1);
    hq = HOST_RDATA;
  endtask
  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    hop(1'b1, a, d);
  endtask
  task automatic hc(input logic [3:0] a, input logic [7:0] x);
    hop(1'b0, a, 8'h00);
    `CHK("host_rdata", x, hq)
  endtask
  task automatic sa(input logic [1:0] w, input logic [14:0] o,
      input logic rg);
    hw(`HESMW_H_ADDR_LO, {o[7:2], w});
    hw(`HESMW_H_ADDR_HI, {rg, o[14:8]});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Whole sequence needs well under this many cycles
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    err_count++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 64; i++) u_mem.mem[i] = pat(i);
    tick(8);
    ARST_N <= 1'b1;
    tick(2);
    `CHK("event_n", 1'b1, HOST_EVENT_OUT_N)
    `CHK("low_power", 1'b1, LOW_POWER)
    ac(`HESMW_A_LIM0, `HESMW_LIM_RST);
    hc(`HESMW_H_MASK_LO, 8'h00);
    $display("test reset done");
    hw(`HESMW_H_H2C, 8'h5a);
    tick(2);
    `CHK("h2c_irq", 1, irq_count)
    ac(`HESMW_A_H2C, 32'h0000_005a);
    ap(1'b1, `HESMW_A_C2H, 32'h0000_00a5);
    tick(2);
    hc(`HESMW_H_C2H, 8'ha5);
    hc(`HESMW_H_SRC_LO, 8'h01);
    `CHK("event_n", 1'b0, HOST_EVENT_OUT_N)
    hw(`HESMW_H_MASK_LO, 8'h01);
    tick(2);
    `CHK("event_n", 1'b1, HOST_EVENT_OUT_N)
    hw(`HESMW_H_MASK_LO, 8'h00);
    hw(`HESMW_H_SRC_LO, 8'h01);
    tick(2);
    `CHK("event_n", 1'b1, HOST_EVENT_OUT_N)
    ap(1'b1, `HESMW_A_SWSET, 32'h0000_0002);
    tick(2);
    hc(`HESMW_H_SRC_LO, 8'h02);
    ac(`HESMW_A_STAT, 32'h0000_0002);
    `CHK("event_n", 1'b0, HOST_EVENT_OUT_N)
    hw(`HESMW_H_SRC_LO, 8'h02);
    ac(12'h020, 32'h0000_0000);
    `CHK("pslverr", 1'b1, aerr)
    $display("test mailbox done");
    ap(1'b1, `HESMW_A_LIM0, 32'h0020_0040);
    ap(1'b1, `HESMW_A_BASE1, 32'h0000_0080);
    ap(1'b1, `HESMW_A_LIM1, 32'h0010_0000);
    ac(`HESMW_A_LIM1, 32'h0010_0000);
    `CHK("pslverr", 1'b0, aerr)
    dly <= 4'h3;
    sa(2'b10, 15'h0008, 1'b0);
    hc(`HESMW_H_ADDR_LO, 8'h0a);
    rc = u_mem.rd_count;
    e = pat(2);
    for (int b = 0; b < 4; b++) hc(4'(4 + b), e[8*b +: 8]);
    `CHK("mem reads", rc + 1, u_mem.rd_count)
    sa(2'b10, 15'h000c, 1'b0);
    for (int b = 0; b < 3; b++) hw(4'(4 + b), 8'(8'h71 + b));
    `CHK("mem word", pat(3), u_mem.mem[3])
    hw(4'h7, 8'h74);
    `CHK("mem word", 32'h7473_7271, u_mem.mem[3])
    sa(2'b01, 15'h0010, 1'b0);
    e = pat(4);
    hc(4'h6, e[23:16]);
    rc = u_mem.rd_count;
    hc(4'h7, e[31:24]);
    `CHK("mem reads", rc, u_mem.rd_count)
    sa(2'b01, 15'h0014, 1'b0);
    e = pat(5);
    hw(4'h6, 8'h62);
    `CHK("mem word", e, u_mem.mem[5])
    hw(4'h7, 8'h63);
    `CHK("mem word", {16'h6362, e[15:0]}, u_mem.mem[5])
    sa(2'b00, 15'h0018, 1'b0);
    e = pat(6);
    hc(4'h5, e[15:8]);
    hw(4'h6, 8'h5c);
    `CHK("mem word", {e[31:24], 8'h5c, e[15:0]}, u_mem.mem[6])
    $display("test widths done");
    dly <= 4'h0;
    sa(2'b11, 15'h0020, 1'b0);
    for (int k = 8; k < 10; k++) begin
      e = pat(k);
      for (int b = 0; b < 4; b++) hc(4'(4 + b), e[8*b +: 8]);
    end
    hc(`HESMW_H_ADDR_LO, 8'h2b);
    sa(2'b11, 15'h001c, 1'b0);
    for (int b = 0; b < 4; b++) hw(4'(4 + b), 8'(8'ha0 + b));
    `CHK("mem word", 32'ha3a2_a1a0, u_mem.mem[7])
    hw(4'h7, 8'hb3);
    `CHK("mem word", pat(8), u_mem.mem[8])
    hc(`HESMW_H_ADDR_LO, 8'h23);
    hc(4'h7, 8'hb3);
    hc(`HESMW_H_ADDR_LO, 8'h27);
    sa(2'b11, 15'h0050, 1'b0);
    rc = u_mem.rd_count;
    hc(4'h4, 8'ha0);
    hc(4'h7, 8'hb3);
    hc(`HESMW_H_ADDR_LO, 8'h57);
    hw(4'h7, 8'hc3);
    hc(`HESMW_H_ADDR_LO, 8'h57);
    `CHK("mem reads", rc, u_mem.rd_count)
    $display("test bounds done");
    sa(2'b10, 15'h0004, 1'b1);
    hc(`HESMW_H_ADDR_HI, 8'h80);
    for (int b = 0; b < 4; b++) hw(4'(4 + b), 8'(8'hd0 + b));
    `CHK("mem word", 32'hd3d2_d1d0, u_mem.mem[33])
    rc = u_mem.rd_count;
    hc(4'h4, 8'hd0);
    `CHK("mem reads", rc, u_mem.rd_count)
    tick(3);
    `CHK("low_power", 1'b1, LOW_POWER)
    `CHK("low_power seen", 1'b1, lp_low != 0)
    ARST_N <= 1'b0;
    tick(2);
    ARST_N <= 1'b1;
    tick(2);
    ac(`HESMW_A_LIM1, `HESMW_LIM_RST);
    hc(`HESMW_H_ADDR_LO, 8'h00);
    $display("test regions done");
    summarize();
  end
endmodule
`default_nettype wire
